// ===== dosdl_far_model.sv
// far-side model: divided ring oscillator and capture phase detector
`timescale 1ns/1ps
module dosdl_far_model (
   input  wire       clk,
   input  wire       osc_en,
   input  wire [7:0] high_ns,
   input  wire [7:0] tap,
   input  wire [7:0] target,
   input  wire [3:0] pd_every,
   output reg        osc_div,
   output reg        early = 1'b0,
   output reg        late = 1'b0
);
   reg [3:0] n_q = 4'h0;
   // free-running divided output, held low while disabled
   initial begin
      osc_div = 1'b0;
      forever begin
         #(high_ns + 1) osc_div = osc_en & ~osc_div;
      end
   end
   // reports against the quarter-period target, every pd_every+1 clocks
   always @(posedge clk) begin
      n_q <= (n_q >= pd_every) ? 4'h0 : n_q + 4'h1;
      early <= (n_q == 4'h0) && tap > target;
      late <= (n_q == 4'h0) && tap < target;
   end
endmodule

// ===== dosdl_map.vh
// constants for the read-path termination, strobe delay and delay-lock block
`ifndef DOSDL_MAP_VH
`define DOSDL_MAP_VH
`define DOSDL_TAP_W           8
`define DOSDL_TAP_MAX         8'hFF
`define DOSDL_DQ_BITS         8
`define DOSDL_QTR_W           10
// termination placement, in quarter clocks
`define DOSDL_ODT_LEAD_QTR    10'h003
`define DOSDL_ODT_TRAIL_QTR   10'h001
`define DOSDL_ODT_LAT_QTR     10'h001
// fixed dq compensation tap, sized for the fastest supported speed
`define DOSDL_DQ_FIXED_TAP    8'h10
`define DOSDL_CNT_W           16
`define DOSDL_SHIFT_CNT_W     8
// calibration sequencer states
`define DOSDL_CAL_IDLE        2'h0
`define DOSDL_CAL_SWEEP       2'h1
`define DOSDL_CAL_DONE        2'h2
`endif

// ===== dosdl_monitor.sv
// port assertions for the read timing block
`timescale 1ns/1ps
module dosdl_monitor (
   input wire        clk,
   input wire        reset_n,
   input wire        rd_cmd,
   input wire [9:0]  preamble_center_qtr,
   input wire [4:0]  burst_len,
   input wire        odt_en_q,
   input wire        cal_start,
   input wire        cal_continuous,
   input wire        cal_busy_q,
   input wire        refresh_window,
   input wire        lock_mode_phase,
   input wire        pd_early,
   input wire        pd_late,
   input wire [31:0] bit_trim,
   input wire        ring_osc_en,
   input wire [7:0]  master_tap_q,
   input wire [7:0]  dqs_tap_q,
   input wire [63:0] slave_tap_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   function [7:0] sat(input [7:0] m, input [3:0] t);
      sat = ({1'b0, m} + t > 9'h0FF) ? 8'hFF : m + t;
   endfunction
   ////////////////////////////////////////////////////////////
   sequence rd_quiet3;
      rd_cmd && preamble_center_qtr < 10'h004 && burst_len == 5'h08 ##1 (!rd_cmd)[*3];
   endsequence
   sequence rd_quiet7;
      rd_cmd && preamble_center_qtr < 10'h004 && burst_len == 5'h08 ##1 (!rd_cmd)[*7];
   endsequence
   ////////////////////////////////////////////////////////////
   odt_on_a: assert property (rd_quiet3 |-> odt_en_q)
      else $error("odt off inside short read");
   odt_off_a: assert property (rd_quiet7 |-> !odt_en_q)
      else $error("odt on after short read");
   tap_hold_a: assert property ($changed(master_tap_q) || $changed(dqs_tap_q) |-> $past(refresh_window))
      else $error("tap moved outside refresh");
   busy_start_a: assert property (cal_start && !cal_busy_q |=> cal_busy_q)
      else $error("sweep did not start");
   busy_idle_a: assert property (!cal_busy_q && !cal_start && !cal_continuous |=> !cal_busy_q)
      else $error("sweep started unasked");
   ring_en_a: assert property (ring_osc_en == !lock_mode_phase)
      else $error("ring enable wrong");
   slave_sync_a: assert property ($changed(master_tap_q) |-> slave_tap_q[7:0] == sat(master_tap_q, $past(bit_trim[3:0])))
      else $error("slave lane not tracking master");
   phase_up_a: assert property ((lock_mode_phase && refresh_window && pd_late && !pd_early)[*4]
      |=> master_tap_q > $past(master_tap_q, 3) || master_tap_q == 8'hFF)
      else $error("master did not step up");
endmodule
bind dosdl_read_timing dosdl_monitor mon (.clk(clk), .reset_n(reset_n), .rd_cmd(rd_cmd),
   .preamble_center_qtr(preamble_center_qtr), .burst_len(burst_len), .odt_en_q(odt_en_q), .cal_start(cal_start),
   .cal_continuous(cal_continuous), .cal_busy_q(cal_busy_q), .refresh_window(refresh_window),
   .lock_mode_phase(lock_mode_phase), .pd_early(pd_early), .pd_late(pd_late), .bit_trim(bit_trim),
   .ring_osc_en(ring_osc_en), .master_tap_q(master_tap_q), .dqs_tap_q(dqs_tap_q), .slave_tap_q(slave_tap_q));

// ===== dosdl_read_timing.v
// read-path termination timing chain, strobe delay calibration and master/slave delay lock
`timescale 1ns/1ps
`include "dosdl_map.vh"

module dosdl_read_timing (
   input  wire                                  clk,
   input  wire                                  reset_n,
   input  wire                                  rd_cmd,
   input  wire [`DOSDL_QTR_W-1:0]               preamble_center_qtr,
   input  wire [4:0]                            burst_len,
   output reg                                   odt_en_q,
   output reg  [1:0]                            odt_edge_sel_q,
   input  wire                                  cal_start,
   input  wire                                  cal_continuous,
   input  wire                                  cal_sample_valid,
   input  wire                                  cal_pass,
   input  wire                                  phase_shift_evt,
   input  wire [`DOSDL_SHIFT_CNT_W-1:0]         shift_limit,
   input  wire                                  refresh_window,
   input  wire                                  lock_mode_phase,
   input  wire                                  ring_osc_div,
   input  wire [`DOSDL_CNT_W-1:0]               ref_count,
   input  wire                                  pd_early,
   input  wire                                  pd_late,
   input  wire                                  dq_comp_fixed,
   input  wire [`DOSDL_DQ_BITS*4-1:0]           bit_trim,
   output wire                                  ring_osc_en,
   output reg                                   cal_busy_q,
   output reg  [`DOSDL_TAP_W-1:0]               master_tap_q,
   output reg  [`DOSDL_TAP_W-1:0]               dqs_tap_q,
   output reg  [`DOSDL_TAP_W-1:0]               dq_comp_tap_q,
   output reg  [`DOSDL_DQ_BITS*`DOSDL_TAP_W-1:0] slave_tap_q
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [`DOSDL_TAP_W-1:0] tap_step;
   input [`DOSDL_TAP_W-1:0] tap;
   input                    up;
   begin
      if (up) begin
         tap_step = (tap == `DOSDL_TAP_MAX) ? tap : tap + 8'h01;
      end else begin
         tap_step = (tap == 8'h00) ? tap : tap - 8'h01;
      end
   end
endfunction

function [`DOSDL_TAP_W-1:0] tap_add_trim;
   input [`DOSDL_TAP_W-1:0] tap;
   input [3:0]              trim;
   reg   [`DOSDL_TAP_W:0]   sum;
   begin
      sum = {1'b0, tap} + {5'h00, trim};
      tap_add_trim = sum[`DOSDL_TAP_W] ? `DOSDL_TAP_MAX : sum[`DOSDL_TAP_W-1:0];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// termination timing chain, quarter clock units

// counts from the cycle the read leaves this domain
reg  [`DOSDL_QTR_W-1:0] chain_qtr_q;
reg                     chain_run_q;
reg  [`DOSDL_QTR_W-1:0] on_qtr_q;
reg  [`DOSDL_QTR_W-1:0] off_qtr_q;
wire [`DOSDL_QTR_W-1:0] lead_total = `DOSDL_ODT_LEAD_QTR + `DOSDL_ODT_LAT_QTR;
wire [`DOSDL_QTR_W-1:0] burst_qtr  = {{(`DOSDL_QTR_W-6){1'b0}}, burst_len, 1'b0};
wire [`DOSDL_QTR_W-1:0] on_calc;
wire [`DOSDL_QTR_W-1:0] off_calc;
wire [`DOSDL_QTR_W-1:0] chain_next = chain_qtr_q + 10'h004;

// both edges measured from preamble centre
// lead of 3/4 clock, trail of 1/4 clock beyond BL/2
// latency compensation pulls both edges earlier
assign on_calc  = (preamble_center_qtr > lead_total) ? preamble_center_qtr - lead_total : 10'h000;
assign off_calc = preamble_center_qtr + burst_qtr + `DOSDL_ODT_TRAIL_QTR - `DOSDL_ODT_LAT_QTR;

always @(posedge clk) begin
   if (!reset_n) begin
      chain_qtr_q    <= 10'h000;
      chain_run_q    <= 1'b0;
      on_qtr_q       <= 10'h000;
      off_qtr_q      <= 10'h000;
      odt_en_q       <= 1'b0;
      odt_edge_sel_q <= 2'h0;
   end else begin
      if (rd_cmd) begin
         chain_qtr_q <= 10'h000;
         chain_run_q <= 1'b1;
         on_qtr_q    <= on_calc;
         off_qtr_q   <= off_calc;
      end else if (chain_run_q) begin
         chain_qtr_q <= chain_next;
         // whole clock from counter, quarter from phase select
         if (on_qtr_q[`DOSDL_QTR_W-1:2] == chain_qtr_q[`DOSDL_QTR_W-1:2]) begin
            odt_en_q       <= 1'b1;
            odt_edge_sel_q <= on_qtr_q[1:0];
         end
         // held through preamble and postamble until off point
         if (off_qtr_q[`DOSDL_QTR_W-1:2] == chain_qtr_q[`DOSDL_QTR_W-1:2]) begin
            odt_en_q       <= 1'b0;
            odt_edge_sel_q <= off_qtr_q[1:0];
            chain_run_q    <= 1'b0;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// strobe eye calibration sweep

reg  [1:0]                    cal_state_q;
reg  [`DOSDL_TAP_W-1:0]       sweep_tap_q;
reg  [`DOSDL_TAP_W-1:0]       first_pass_q;
reg  [`DOSDL_TAP_W-1:0]       last_pass_q;
reg                           seen_pass_q;
reg  [`DOSDL_TAP_W-1:0]       cal_result_q;
reg                           cal_pend_q;
reg  [`DOSDL_SHIFT_CNT_W-1:0] shift_cnt_q;
wire                          shift_trig = (shift_cnt_q >= shift_limit) && (shift_limit != 8'h00);
wire [`DOSDL_TAP_W:0]         eye_sum = {1'b0, first_pass_q} + {1'b0, last_pass_q};

always @(posedge clk) begin
   if (!reset_n) begin
      cal_state_q  <= `DOSDL_CAL_IDLE;
      sweep_tap_q  <= 8'h00;
      first_pass_q <= 8'h00;
      last_pass_q  <= 8'h00;
      seen_pass_q  <= 1'b0;
      cal_result_q <= 8'h00;
      cal_pend_q   <= 1'b0;
      cal_busy_q   <= 1'b0;
      shift_cnt_q  <= 8'h00;
   end else begin
      // accumulate phase shifts, a new shift beats the clear
      if (phase_shift_evt) begin
         shift_cnt_q <= (cal_state_q == `DOSDL_CAL_IDLE && shift_trig) ? 8'h01 : shift_cnt_q + 8'h01;
      end else if (cal_state_q == `DOSDL_CAL_IDLE && shift_trig) begin
         shift_cnt_q <= 8'h00;
      end
      if (refresh_window) begin
         cal_pend_q <= 1'b0;
      end
      case (cal_state_q)
         `DOSDL_CAL_IDLE: begin
            // one-shot start, or rerun on phase drift when continuous
            if (cal_start || (cal_continuous && shift_trig)) begin
               cal_state_q <= `DOSDL_CAL_SWEEP;
               sweep_tap_q <= 8'h00;
               seen_pass_q <= 1'b0;
               cal_busy_q  <= 1'b1;
            end
         end
         `DOSDL_CAL_SWEEP: begin
            if (cal_sample_valid) begin
               if (cal_pass) begin
                  if (!seen_pass_q) begin
                     first_pass_q <= sweep_tap_q;
                  end
                  last_pass_q <= sweep_tap_q;
                  seen_pass_q <= 1'b1;
               end
               if (sweep_tap_q == `DOSDL_TAP_MAX) begin
                  cal_state_q <= `DOSDL_CAL_DONE;
               end else begin
                  sweep_tap_q <= sweep_tap_q + 8'h01;
               end
            end
         end
         `DOSDL_CAL_DONE: begin
            // centre of the passing window is the quarter-period point
            if (seen_pass_q) begin
               cal_result_q <= eye_sum[`DOSDL_TAP_W:1];
               cal_pend_q   <= 1'b1;
            end
            cal_busy_q  <= 1'b0;
            cal_state_q <= `DOSDL_CAL_IDLE;
         end
         default: begin
            cal_state_q <= `DOSDL_CAL_IDLE;
            cal_busy_q  <= 1'b0;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// ring oscillator measurement

// oscillator free-runs near 2x dram clock while ring mode is locking
assign ring_osc_en = !lock_mode_phase;

// two-stage resynchroniser for the divided oscillator
reg                    ring_s1_q;
reg                    ring_s2_q;
reg                    ring_s3_q;
reg [`DOSDL_CNT_W-1:0] high_cnt_q;
reg                    ring_inc_q;
reg                    ring_dec_q;

always @(posedge clk) begin
   if (!reset_n) begin
      ring_s1_q  <= 1'b0;
      ring_s2_q  <= 1'b0;
      ring_s3_q  <= 1'b0;
      high_cnt_q <= 16'h0000;
      ring_inc_q <= 1'b0;
      ring_dec_q <= 1'b0;
   end else begin
      ring_s1_q  <= ring_osc_div;
      ring_s2_q  <= ring_s1_q;
      ring_s3_q  <= ring_s2_q;
      ring_inc_q <= 1'b0;
      ring_dec_q <= 1'b0;
      if (ring_s2_q && !ring_s3_q) begin
         // fresh count at each window start
         high_cnt_q <= 16'h0001;
      end else if (ring_s2_q) begin
         // base clocks spent in the high phase
         high_cnt_q <= (high_cnt_q == 16'hFFFF) ? high_cnt_q : high_cnt_q + 16'h0001;
      end else if (!ring_s2_q && ring_s3_q && ring_osc_en) begin
         ring_inc_q <= (high_cnt_q > ref_count);
         ring_dec_q <= (high_cnt_q < ref_count);
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// master lock and distribution

reg [`DOSDL_TAP_W-1:0] master_pend_q;

always @(posedge clk) begin
   if (!reset_n) begin
      master_pend_q <= 8'h00;
   end else if (lock_mode_phase) begin
      // capture-fifo phase detector steps the target
      // detector balances at the quarter-period master delay
      if (pd_late && !pd_early) begin
         master_pend_q <= tap_step(master_pend_q, 1'b1);
      end else if (pd_early && !pd_late) begin
         master_pend_q <= tap_step(master_pend_q, 1'b0);
      end
   end else if (ring_inc_q) begin
      master_pend_q <= tap_step(master_pend_q, 1'b1);
   end else if (ring_dec_q) begin
      master_pend_q <= tap_step(master_pend_q, 1'b0);
   end
end

integer i;

always @(posedge clk) begin
   if (!reset_n) begin
      master_tap_q  <= 8'h00;
      dqs_tap_q     <= 8'h00;
      dq_comp_tap_q <= `DOSDL_DQ_FIXED_TAP;
      slave_tap_q   <= {(`DOSDL_DQ_BITS*`DOSDL_TAP_W){1'b0}};
   end else if (refresh_window) begin
      // delay lines only change while the bus is idle
      master_tap_q <= master_pend_q;
      if (cal_pend_q) begin
         dqs_tap_q <= cal_result_q;
      end
      // dq path compensation against strobe insertion
      // fixed value sized for top speed when dq_comp_fixed, else follows the calibrated strobe tap
      dq_comp_tap_q <= dq_comp_fixed ? `DOSDL_DQ_FIXED_TAP : (cal_pend_q ? cal_result_q : dqs_tap_q);
      // per-bit slaves from the master plus bit trim
      for (i = 0; i < `DOSDL_DQ_BITS; i = i + 1) begin
         slave_tap_q[i*`DOSDL_TAP_W +: `DOSDL_TAP_W] <= tap_add_trim(master_pend_q, bit_trim[i*4 +: 4]);
      end
   end
end

endmodule

// ===== testbench.sv
// self-checking bench for the read timing block
`timescale 1ns/1ps
module testbench;
   reg         clk = 1'b0, reset_n = 1'b0, rd_cmd = 1'b0, cs = 1'b0, cc = 1'b0, sv = 1'b0, cp = 1'b0;
   reg         pse = 1'b0, rw = 1'b0, lmp = 1'b1, dqf = 1'b0;
   reg  [9:0]  pc = 10'h000;
   reg  [4:0]  bl = 5'h08;
   reg  [7:0]  slim = 8'h00, hns = 8'h50, tgt = 8'h00;
   reg  [15:0] refc = 16'h0000;
   reg  [31:0] trim = 32'h00000000, lfsr = 32'h987A2039;
   reg  [3:0]  pde = 4'h0;
   wire        odt, roe, busy, osc, pe, pl;
   wire [1:0]  esel;
   wire [7:0]  mt, dt, ct;
   wire [63:0] st;
   integer     err_count = 0, checks = 0, cyc = 0, k, i, t0, t1, e;
   dosdl_read_timing uut (.clk(clk), .reset_n(reset_n), .rd_cmd(rd_cmd), .preamble_center_qtr(pc), .burst_len(bl),
      .odt_en_q(odt), .odt_edge_sel_q(esel), .cal_start(cs), .cal_continuous(cc), .cal_sample_valid(sv),
      .cal_pass(cp), .phase_shift_evt(pse), .shift_limit(slim), .refresh_window(rw), .lock_mode_phase(lmp),
      .ring_osc_div(osc), .ref_count(refc), .pd_early(pe), .pd_late(pl), .dq_comp_fixed(dqf), .bit_trim(trim),
      .ring_osc_en(roe), .cal_busy_q(busy), .master_tap_q(mt), .dqs_tap_q(dt), .dq_comp_tap_q(ct), .slave_tap_q(st));
   dosdl_far_model far (.clk(clk), .osc_en(roe), .high_ns(hns), .tap(mt), .target(tgt), .pd_every(pde),
      .osc_div(osc), .early(pe), .late(pl));
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////
   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function [7:0] sat(input [7:0] m, input [3:0] t);
      sat = ({1'b0, m} + t > 9'h0FF) ? 8'hFF : m + t;
   endfunction
   task chk(input [8*10-1:0] nm, input [63:0] ex, input [63:0] got);
      begin
         checks = checks + 1;
         if (got !== ex) begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %0h seen %0h", nm, ex, got);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", checks, err_count);
         if (err_count == 0 && checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc > 12000) begin
         err_count = err_count + 1;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////
   task wait_busy(input v);
      for (e = 0; e < 20 && busy !== v; e = e + 1) @(posedge clk) #1;
   endtask
   task pulse_rw;
      begin
         @(posedge clk) rw <= 1'b1;
         @(posedge clk) rw <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task odt_run(input [9:0] c, input [4:0] l);
      reg [10:0] on, off;
      begin
         on = (c < 4) ? 11'h000 : c - 4;
         off = c + 2 * l;
         @(posedge clk) rd_cmd <= 1'b1;
         pc <= c;
         bl <= l;
         @(posedge clk) rd_cmd <= 1'b0;
         t0 = -1;
         t1 = -1;
         for (k = 0; k < 300 && t1 < 0; k = k + 1) begin
            @(posedge clk) #1;
            if (odt === 1'b1 && t0 < 0) t0 = k;
            if (odt === 1'b0 && t0 >= 0) t1 = k;
         end
         chk("odt_len", (off >> 2) - (on >> 2), t1 - t0);
         chk("edge_sel", off[1:0], esel);
      end
   endtask
   task samples(input integer lo, input integer hi);
      begin
         for (k = 0; k < 256; k = k + 1) begin
            @(posedge clk) sv <= 1'b1;
            cp <= (k >= lo && k <= hi);
            cs <= (k == 9);
         end
         @(posedge clk) sv <= 1'b0;
         cs <= 1'b0;
         wait_busy(1'b0);
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk("odt", 0, odt);
      chk("dq_comp", 8'h10, ct);
      chk("slaves", 0, st);
      odt_run(10'h000, 5'h08);
      odt_run(10'h003, 5'h04);
      for (i = 0; i < 10; i = i + 1) begin
         lfsr = nx(lfsr);
         odt_run(lfsr[9:0] % 700, lfsr[12] ? 5'h08 : 5'h04);
      end
      lfsr = nx(lfsr);
      t0 = lfsr[7:0] % 200;
      t1 = t0 + 1 + lfsr[13:8] % 50;
      i = (t0 + t1) / 2;
      @(posedge clk) cs <= 1'b1;
      @(posedge clk) cs <= 1'b0;
      #1 chk("busy", 1, busy);
      samples(t0, t1);
      chk("dqs_wait", 0, dt);
      pulse_rw;
      chk("dqs_tap", i, dt);
      chk("dq_comp", i, ct);
      @(posedge clk) cc <= 1'b1;
      slim <= 8'h03;
      for (k = 0; k < 5; k = k + 1) @(posedge clk) pse <= (k == 1 || k == 3);
      repeat (4) @(posedge clk);
      #1 chk("busy_two", 0, busy);
      @(posedge clk) pse <= 1'b1;
      @(posedge clk) pse <= 1'b0;
      wait_busy(1'b1);
      chk("busy_shift", 1, busy);
      @(posedge clk) cc <= 1'b0;
      samples(300, 300);
      pulse_rw;
      chk("dqs_keep", i, dt);
      @(posedge clk) dqf <= 1'b1;
      pulse_rw;
      chk("dq_fixed", 8'h10, ct);
      lfsr = nx(lfsr);
      @(posedge clk) tgt <= 8'h14 + lfsr[6:0] % 100;
      trim <= lfsr;
      rw <= 1'b1;
      repeat (40) @(posedge clk);
      pde <= 4'h7;
      repeat (1200) @(posedge clk);
      #1 chk("master", tgt, mt);
      for (i = 0; i < 8; i = i + 1) chk("slave", sat(tgt, trim[4*i +: 4]), st[8*i +: 8]);
      @(posedge clk) lmp <= 1'b0;
      refc <= 16'h0002;
      #1 chk("ring_en", 1, roe);
      repeat (300) @(posedge clk);
      #1 chk("ring_up", 1, mt > tgt);
      t0 = mt;
      @(posedge clk) refc <= 16'h00FF;
      repeat (300) @(posedge clk);
      #1 chk("ring_down", 1, mt < t0);
      final_report;
   end
endmodule
